// ===== rtl/servo_gain_direction_stop_select.sv
// Summary of operation
// - no rigidity, no orientation, no position request before switch complete: speed gain, integral, position gain set 1
// - rigidity on: speed gain and integral set 2, position gain set 1
// - orientation, or position request before switch complete: all set 3
// - rigidity on selects the alternate analog command setting
// - position mode: direction reverse bit inverts pulse command direction
// - bipolar: positive gives CCW, negative CW; reverse bit swaps
// - unipolar: CCW input gives CCW, CW input CW; reverse bit swaps
// - speed mode: speed reversal makes the displayed speed sign negative
// - enable drop picks natural stop (0) or braking stop (1, default)
// - natural stop removes motor power at once, no torque
// - braking stop applies reverse torque for set duration, then power off
//
// The AXI4-Lite slave port and the address map were left to the implementer.
`timescale 1ns/1ns
`include "servo_sel_consts.svh"
module servo_gain_direction_stop_select #(
	parameter int GW = 16
) (
	input  wire logic          clk_sys,
	input  wire logic          sys_rst,
	input  wire logic          ce,
	input  wire logic          ctrl_tick,
	input  wire logic          rigid_tap_request,
	input  wire logic          orient_request,
	input  wire logic          position_mode_request,
	input  wire logic          switch_complete_out,
	input  wire logic          enable_in,
	input  wire logic          analog_cmd_positive,
	input  wire logic          ccw_run_input,
	input  wire logic          cw_run_input,
	input  wire logic          pulse_dir_ccw,
	output logic [GW-1:0]      speed_gain_sel,
	output logic [GW-1:0]      speed_integral_sel,
	output logic [GW-1:0]      pos_gain_sel,
	output logic [GW-1:0]      analog_cmd_setting_sel,
	output logic [1:0]         gain_set_q,
	output logic               motor_dir_ccw_q,
	output logic               run_active_q,
	output logic               speed_sign_neg_q,
	output logic               motor_power_q,
	output logic               reverse_torque_q,
	input  wire logic [7:0]    s_axi_awaddr,
	input  wire logic          s_axi_awvalid,
	output logic               s_axi_awready,
	input  wire logic [31:0]   s_axi_wdata,
	input  wire logic [3:0]    s_axi_wstrb,
	input  wire logic          s_axi_wvalid,
	output logic               s_axi_wready,
	output logic [1:0]         s_axi_bresp,
	output logic               s_axi_bvalid,
	input  wire logic          s_axi_bready,
	input  wire logic [7:0]    s_axi_araddr,
	input  wire logic          s_axi_arvalid,
	output logic               s_axi_arready,
	output logic [31:0]        s_axi_rdata,
	output logic [1:0]         s_axi_rresp,
	output logic               s_axi_rvalid,
	input  wire logic          s_axi_rready
);
	logic [31:0]               cfg_q [0:`N_CFG-1];
	logic                      aw_got_q;
	logic                      w_got_q;
	logic [7:0]                aw_addr_q;
	logic [31:0]               w_data_q;
	logic [3:0]                w_strb_q;
	logic                      rigid_s;
	logic                      orient_s;
	logic                      posm_s;
	logic                      swd_s;
	logic                      en_s;
	logic                      apos_s;
	logic                      ccw_s;
	logic                      cw_s;
	logic                      pdir_s;
	logic [GW-1:0]             brk_cnt_q;
	servo_sel_pkg::stop_state_t st_q;
	logic                      step;
	logic                      g3_req;
	logic [3:0]                aw_idx;
	logic [3:0]                ar_idx;
	logic                      aw_ok;
	logic                      ar_ok;
	logic [31:0]               bmask;
	logic [31:0]               wmask;

	// one step of the control logic per enabled update tick
	assign step   = ce && ctrl_tick;
	assign g3_req = orient_s || (posm_s && !swd_s);
	assign aw_idx = aw_addr_q[5:2];
	assign ar_idx = s_axi_araddr[5:2];
	assign aw_ok  = (aw_addr_q[7:6] == 2'h0) && (aw_idx < 4'(`N_CFG));
	assign ar_ok  = (s_axi_araddr[7:6] == 2'h0) && (ar_idx <= `I_STATUS);
	assign bmask  = {{8{w_strb_q[3]}}, {8{w_strb_q[2]}}, {8{w_strb_q[1]}}, {8{w_strb_q[0]}}};
	assign wmask  = (aw_idx == `I_CTRL) ? `M_CTRL : `M_WORD;

	// input sampling on the system clock
	always_ff @(posedge clk_sys) begin
		if (sys_rst) begin
			rigid_s <= 1'b0;
			orient_s <= 1'b0;
			posm_s <= 1'b0;
			swd_s <= 1'b0;
			en_s <= 1'b0;
			apos_s <= 1'b0;
			ccw_s <= 1'b0;
			cw_s <= 1'b0;
			pdir_s <= 1'b0;
		end else if (ce) begin
			rigid_s <= rigid_tap_request;
			orient_s <= orient_request;
			posm_s <= position_mode_request;
			swd_s <= switch_complete_out;
			en_s <= enable_in;
			apos_s <= analog_cmd_positive;
			ccw_s <= ccw_run_input;
			cw_s <= cw_run_input;
			pdir_s <= pulse_dir_ccw;
		end
	end

	// gain set choice, orientation first, applied only at a tick
	always_ff @(posedge clk_sys) begin
		if (sys_rst) begin
			gain_set_q <= servo_sel_pkg::GS_1;
			speed_gain_sel <= '0;
			speed_integral_sel <= '0;
			pos_gain_sel <= '0;
			analog_cmd_setting_sel <= '0;
		end else if (step) begin
			if (g3_req) begin
				gain_set_q <= servo_sel_pkg::GS_3;
				speed_gain_sel <= cfg_q[`I_SPG3][GW-1:0];
				speed_integral_sel <= cfg_q[`I_SPI3][GW-1:0];
				pos_gain_sel <= cfg_q[`I_PG3][GW-1:0];
			end else if (rigid_s) begin
				gain_set_q <= servo_sel_pkg::GS_2;
				speed_gain_sel <= cfg_q[`I_SPG2][GW-1:0];
				speed_integral_sel <= cfg_q[`I_SPI2][GW-1:0];
				pos_gain_sel <= cfg_q[`I_PG1][GW-1:0];
			end else begin
				gain_set_q <= servo_sel_pkg::GS_1;
				speed_gain_sel <= cfg_q[`I_SPG1][GW-1:0];
				speed_integral_sel <= cfg_q[`I_SPI1][GW-1:0];
				pos_gain_sel <= cfg_q[`I_PG1][GW-1:0];
			end
			// alternate analog setting while rigid tapping
			if (rigid_s) begin
				analog_cmd_setting_sel <= cfg_q[`I_ACS_ALT][GW-1:0];
			end else begin
				analog_cmd_setting_sel <= cfg_q[`I_ACS_STD][GW-1:0];
			end
		end
	end

	// rotation direction and display sign
	always_ff @(posedge clk_sys) begin
		if (sys_rst) begin
			motor_dir_ccw_q <= 1'b1;
			run_active_q <= 1'b0;
			speed_sign_neg_q <= 1'b0;
		end else if (step) begin
			if (posm_s) begin
				motor_dir_ccw_q <= pdir_s ^ cfg_q[`I_CTRL][`F_POS_REV];
				run_active_q <= 1'b1;
				speed_sign_neg_q <= 1'b0;
			end else if (!cfg_q[`I_CTRL][`F_UNIPOLAR]) begin
				motor_dir_ccw_q <= apos_s ^ cfg_q[`I_CTRL][`F_SPD_REV];
				run_active_q <= 1'b1;
				speed_sign_neg_q <= cfg_q[`I_CTRL][`F_SPD_REV];
			end else begin
				// ccw input wins when both run inputs are on
				motor_dir_ccw_q <= (ccw_s || !cw_s) ^ cfg_q[`I_CTRL][`F_SPD_REV];
				run_active_q <= ccw_s || cw_s;
				speed_sign_neg_q <= cfg_q[`I_CTRL][`F_SPD_REV];
			end
		end
	end

	// stop sequencer: run, natural stop or timed braking stop
	always_ff @(posedge clk_sys) begin
		if (sys_rst) begin
			st_q <= servo_sel_pkg::ST_OFF;
			brk_cnt_q <= '0;
			motor_power_q <= 1'b0;
			reverse_torque_q <= 1'b0;
		end else if (step) begin
			unique case (st_q)
				servo_sel_pkg::ST_OFF: begin
					if (en_s) begin
						st_q <= servo_sel_pkg::ST_RUN;
						motor_power_q <= 1'b1;
					end
				end
				servo_sel_pkg::ST_RUN: begin
					if (!en_s && cfg_q[`I_CTRL][`F_BRAKE_SEL]) begin
						st_q <= servo_sel_pkg::ST_BRAKE;
						brk_cnt_q <= cfg_q[`I_BRK_DUR][GW-1:0];
						reverse_torque_q <= 1'b1;
					end else if (!en_s) begin
						st_q <= servo_sel_pkg::ST_OFF;
						motor_power_q <= 1'b0;
					end
				end
				servo_sel_pkg::ST_BRAKE: begin
					// braking runs to its end even if enable returns
					// the load tick counts as the first, so a duration of 0 or 1 gives one tick
					if (brk_cnt_q[GW-1:1] == '0) begin
						st_q <= servo_sel_pkg::ST_OFF;
						motor_power_q <= 1'b0;
						reverse_torque_q <= 1'b0;
					end else begin
						brk_cnt_q <= brk_cnt_q - 1'b1;
					end
				end
				default: begin
					st_q <= servo_sel_pkg::ST_OFF;
					motor_power_q <= 1'b0;
					reverse_torque_q <= 1'b0;
				end
			endcase
		end
	end

	// write channel: address and data taken in either order
	always_ff @(posedge clk_sys) begin
		if (sys_rst) begin
			aw_got_q <= 1'b0;
			w_got_q <= 1'b0;
			aw_addr_q <= '0;
			w_data_q <= '0;
			w_strb_q <= '0;
			s_axi_awready <= 1'b1;
			s_axi_wready <= 1'b1;
			s_axi_bvalid <= 1'b0;
			s_axi_bresp <= `RESP_OKAY;
		end else if (ce) begin
			if (s_axi_awvalid && s_axi_awready) begin
				aw_got_q <= 1'b1;
				aw_addr_q <= s_axi_awaddr;
				s_axi_awready <= 1'b0;
			end
			if (s_axi_wvalid && s_axi_wready) begin
				w_got_q <= 1'b1;
				w_data_q <= s_axi_wdata;
				w_strb_q <= s_axi_wstrb;
				s_axi_wready <= 1'b0;
			end
			if (aw_got_q && w_got_q && !s_axi_bvalid) begin
				aw_got_q <= 1'b0;
				w_got_q <= 1'b0;
				s_axi_bvalid <= 1'b1;
				s_axi_bresp <= aw_ok ? `RESP_OKAY : `RESP_SLVERR;
			end
			if (s_axi_bvalid && s_axi_bready) begin
				s_axi_bvalid <= 1'b0;
				s_axi_awready <= 1'b1;
				s_axi_wready <= 1'b1;
			end
		end
	end

	// register words, byte lanes merged, unused bits kept zero
	always_ff @(posedge clk_sys) begin
		if (sys_rst) begin
			for (int i = 0; i < `N_CFG; i++) begin
				cfg_q[i] <= (i == 0) ? `RST_CTRL : `RST_WORD;
			end
		end else if (ce && aw_got_q && w_got_q && !s_axi_bvalid && aw_ok) begin
			cfg_q[aw_idx] <= ((cfg_q[aw_idx] & ~bmask) | (w_data_q & bmask)) & wmask;
		end
	end

	// read channel, status word assembled from live state
	always_ff @(posedge clk_sys) begin
		if (sys_rst) begin
			s_axi_arready <= 1'b1;
			s_axi_rvalid <= 1'b0;
			s_axi_rdata <= '0;
			s_axi_rresp <= `RESP_OKAY;
		end else if (ce) begin
			if (s_axi_arvalid && s_axi_arready) begin
				s_axi_arready <= 1'b0;
				s_axi_rvalid <= 1'b1;
				s_axi_rresp <= ar_ok ? `RESP_OKAY : `RESP_SLVERR;
				if (!ar_ok) begin
					s_axi_rdata <= '0;
				end else if (ar_idx == `I_STATUS) begin
					s_axi_rdata <= {21'h0, swd_s, posm_s, st_q, gain_set_q,
						reverse_torque_q, motor_power_q, speed_sign_neg_q,
						run_active_q, motor_dir_ccw_q};
				end else begin
					s_axi_rdata <= cfg_q[ar_idx];
				end
			end
			if (s_axi_rvalid && s_axi_rready) begin
				s_axi_rvalid <= 1'b0;
				s_axi_arready <= 1'b1;
			end
		end
	end

	property p_gain1;
		@(posedge clk_sys) disable iff (sys_rst)
		(step && !g3_req && !rigid_s) |=> (gain_set_q == servo_sel_pkg::GS_1);
	endproperty
	a_gain1: assert property (p_gain1) else $error("gain set 1 not applied");

	property p_gain2;
		@(posedge clk_sys) disable iff (sys_rst)
		(step && !g3_req && rigid_s) |=> (gain_set_q == servo_sel_pkg::GS_2);
	endproperty
	a_gain2: assert property (p_gain2) else $error("gain set 2 not applied");

	property p_gain3;
		@(posedge clk_sys) disable iff (sys_rst)
		(step && (orient_s || (posm_s && !swd_s))) |=> (gain_set_q == servo_sel_pkg::GS_3);
	endproperty
	a_gain3: assert property (p_gain3) else $error("gain set 3 not applied");

	property p_alt;
		@(posedge clk_sys) disable iff (sys_rst)
		(step && rigid_s) |=> (analog_cmd_setting_sel == $past(cfg_q[`I_ACS_ALT][GW-1:0]));
	endproperty
	a_alt: assert property (p_alt) else $error("alternate analog setting missing");

	property p_posdir;
		@(posedge clk_sys) disable iff (sys_rst)
		(step && posm_s) |=> (motor_dir_ccw_q == ($past(pdir_s) ^ $past(cfg_q[`I_CTRL][0])));
	endproperty
	a_posdir: assert property (p_posdir) else $error("position direction wrong");

	property p_bipolar;
		@(posedge clk_sys) disable iff (sys_rst)
		(step && !posm_s && !cfg_q[`I_CTRL][`F_UNIPOLAR])
		|=> (motor_dir_ccw_q == ($past(apos_s) ^ $past(cfg_q[`I_CTRL][1])));
	endproperty
	a_bipolar: assert property (p_bipolar) else $error("bipolar direction wrong");

	property p_unipolar;
		@(posedge clk_sys) disable iff (sys_rst)
		(step && !posm_s && cfg_q[`I_CTRL][`F_UNIPOLAR] && ccw_s)
		|=> (motor_dir_ccw_q != $past(cfg_q[`I_CTRL][1])) && run_active_q;
	endproperty
	a_unipolar: assert property (p_unipolar) else $error("unipolar direction wrong");

	property p_sign;
		@(posedge clk_sys) disable iff (sys_rst)
		(step && !posm_s) |=> (speed_sign_neg_q == $past(cfg_q[`I_CTRL][1]));
	endproperty
	a_sign: assert property (p_sign) else $error("display sign wrong");

	property p_natural;
		@(posedge clk_sys) disable iff (sys_rst)
		(step && st_q == servo_sel_pkg::ST_RUN && !en_s && !cfg_q[`I_CTRL][3])
		|=> !motor_power_q && !reverse_torque_q;
	endproperty
	a_natural: assert property (p_natural) else $error("natural stop kept power");

	property p_brake;
		@(posedge clk_sys) disable iff (sys_rst)
		(step && st_q == servo_sel_pkg::ST_RUN && !en_s && cfg_q[`I_CTRL][3])
		|=> motor_power_q && reverse_torque_q && (st_q == servo_sel_pkg::ST_BRAKE);
	endproperty
	a_brake: assert property (p_brake) else $error("braking stop not entered");

	property p_hold;
		@(posedge clk_sys) disable iff (sys_rst)
		!step |=> $stable(gain_set_q) && $stable(st_q);
	endproperty
	a_hold: assert property (p_hold) else $error("state changed off tick");
endmodule : servo_gain_direction_stop_select

// ===== common/servo_sel_consts.svh
`ifndef SERVO_SEL_CONSTS_SVH
`define SERVO_SEL_CONSTS_SVH
// byte addresses of the register words
`define A_CTRL      8'h00
`define A_BRK_DUR   8'h04
`define A_STATUS    8'h30
// word indices: control, brake duration, then the ten loop settings
`define I_CTRL      4'h0
`define I_BRK_DUR   4'h1
`define I_SPG1      4'h2
`define I_SPI1      4'h3
`define I_PG1       4'h4
`define I_SPG2      4'h5
`define I_SPI2      4'h6
`define I_SPG3      4'h7
`define I_SPI3      4'h8
`define I_PG3       4'h9
`define I_ACS_STD   4'hA
`define I_ACS_ALT   4'hB
`define I_STATUS    4'hC
`define N_CFG       12
// control word fields
`define F_POS_REV   0
`define F_SPD_REV   1
`define F_UNIPOLAR  2
`define F_BRAKE_SEL 3
// reset values and writable masks
`define RST_CTRL    32'h0000_0008
`define RST_WORD    32'h0000_0000
`define M_CTRL      32'h0000_000F
`define M_WORD      32'h0000_FFFF
// bus answers
`define RESP_OKAY   2'h0
`define RESP_SLVERR 2'h2
`endif

// ===== common/servo_sel_pkg.sv
package servo_sel_pkg;
	typedef enum logic [1:0] {
		ST_OFF   = 2'b00,
		ST_RUN   = 2'b01,
		ST_BRAKE = 2'b10
	} stop_state_t;
	typedef enum logic [1:0] {
		GS_1 = 2'b01,
		GS_2 = 2'b10,
		GS_3 = 2'b11
	} gain_set_t;
endpackage : servo_sel_pkg

// ===== tb/cnc_model.sv
`timescale 1ns/1ns
module cnc_model (
	input  wire logic       clk_sys,
	input  wire logic       sys_rst,
	input  wire logic [8:0] want,
	output logic      [8:0] mode,
	output logic            tick
);
	logic [8:0] mode_q;
	logic [1:0] div_q;
	// mode lines move just after an edge, as a controller's outputs would
	always_ff @(posedge clk_sys) begin
		mode_q <= want;
	end
	// update strobe divider, one cycle in four
	always_ff @(posedge clk_sys) begin
		if (sys_rst) begin
			div_q <= 2'h0;
		end else begin
			div_q <= div_q + 2'h1;
		end
	end
	// bit 2 held low in reset keeps speed mode as the default request
	assign mode = sys_rst ? 9'h000 : mode_q;
	assign tick = !sys_rst && (div_q == 2'h3);
endmodule : cnc_model

// ===== tb/servo_gain_direction_stop_select_bench.sv
`timescale 1ns/1ns
`include "servo_sel_consts.svh"
module servo_gain_direction_stop_select_bench;
	logic        clk_sys, sys_rst, ce, ctrl_tick;
	logic [8:0]  want, mode, m;
	logic [15:0] sg, si, pg, acs;
	logic [1:0]  gs, r;
	logic        dir, run, sgn, pwr, trq;
	logic [7:0]  awaddr, araddr;
	logic [31:0] wdata, rdata, d, ctl;
	logic        awvalid, wvalid, bready, arvalid, rready;
	logic        awready, wready, bvalid, arready, rvalid;
	logic [1:0]  bresp, rresp;
	logic [3:0]  wstrb;
	logic [15:0] cfg [12];
	int          n_errors, compares, i;
	// mode bits: 0 rigid 1 orient 2 position 3 switch done 4 enable 5 sign 6 ccw 7 cw 8 pulse dir
	cnc_model i_cnc_model (.clk_sys(clk_sys), .sys_rst(sys_rst), .want(want), .mode(mode),
		.tick(ctrl_tick));
	servo_gain_direction_stop_select i_servo_gain_direction_stop_select (
		.clk_sys(clk_sys), .sys_rst(sys_rst), .ce(ce), .ctrl_tick(ctrl_tick),
		.rigid_tap_request(mode[0]), .orient_request(mode[1]),
		.position_mode_request(mode[2]), .switch_complete_out(mode[3]), .enable_in(mode[4]),
		.analog_cmd_positive(mode[5]), .ccw_run_input(mode[6]), .cw_run_input(mode[7]),
		.pulse_dir_ccw(mode[8]), .speed_gain_sel(sg), .speed_integral_sel(si),
		.pos_gain_sel(pg), .analog_cmd_setting_sel(acs), .gain_set_q(gs),
		.motor_dir_ccw_q(dir), .run_active_q(run), .speed_sign_neg_q(sgn),
		.motor_power_q(pwr), .reverse_torque_q(trq), .s_axi_awaddr(awaddr),
		.s_axi_awvalid(awvalid), .s_axi_awready(awready), .s_axi_wdata(wdata),
		.s_axi_wstrb(wstrb), .s_axi_wvalid(wvalid), .s_axi_wready(wready),
		.s_axi_bresp(bresp), .s_axi_bvalid(bvalid), .s_axi_bready(bready),
		.s_axi_araddr(araddr), .s_axi_arvalid(arvalid), .s_axi_arready(arready),
		.s_axi_rdata(rdata), .s_axi_rresp(rresp), .s_axi_rvalid(rvalid), .s_axi_rready(rready));
	// 125 MHz system clock
	initial begin
		clk_sys = 1'b0;
		forever #4 clk_sys = ~clk_sys;
	end
	task end_of_test;
		$display("n_errors %0d compares %0d", n_errors, compares);
		if (n_errors == 0 && compares > 0) $display("Simulation passed");
		else $display("Simulation failed");
		$finish;
	endtask : end_of_test
	task hang;
		n_errors++;
		$display("unexpected at %0t: wait ran out", $time);
		end_of_test();
	endtask : hang
	task chk(input logic [31:0] seen, input logic [31:0] exp);
		compares++;
		if (seen !== exp) begin
			n_errors++;
			$display("unexpected at %0t: saw %h, wanted %h", $time, seen, exp);
		end
	endtask : chk
	// write: address and data offered together, each dropped when taken
	// bready and rready stay high for the whole run, so no call has to toggle them
	task axw(input logic [7:0] a, input logic [31:0] v, output logic [1:0] rsp);
		int k;
		awaddr <= a;
		wdata <= v;
		awvalid <= 1'b1;
		wvalid <= 1'b1;
		for (k = 0; k < 50; k++) begin
			@(posedge clk_sys);
			if (awvalid && awready) awvalid <= 1'b0;
			if (wvalid && wready) wvalid <= 1'b0;
			if (bvalid) break;
		end
		rsp = bresp;
		if (k == 50) hang();
	endtask : axw
	task axr(input logic [7:0] a, output logic [31:0] v, output logic [1:0] rsp);
		int k;
		araddr <= a;
		arvalid <= 1'b1;
		for (k = 0; k < 50; k++) begin
			@(posedge clk_sys);
			if (arvalid && arready) arvalid <= 1'b0;
			if (rvalid) break;
		end
		v = rdata;
		rsp = rresp;
		if (k == 50) hang();
	endtask : axr
	// wait for n update strobes, then one more edge so outputs are read settled
	task ticks(input int n);
		int k, seen;
		seen = 0;
		for (k = 0; k < 100 && seen < n; k++) begin
			@(posedge clk_sys);
			if (ctrl_tick) seen++;
		end
		if (seen < n) hang();
		@(posedge clk_sys);
	endtask : ticks
	function automatic logic [1:0] exp_set(input logic [8:0] mm);
		if (mm[1] || (mm[2] && !mm[3])) return servo_sel_pkg::GS_3;
		if (mm[0]) return servo_sel_pkg::GS_2;
		return servo_sel_pkg::GS_1;
	endfunction : exp_set
	function automatic logic [15:0] pick(input logic [8:0] mm, input int s1, s2, s3);
		if (exp_set(mm) == servo_sel_pkg::GS_3) return cfg[s3];
		if (exp_set(mm) == servo_sel_pkg::GS_2) return cfg[s2];
		return cfg[s1];
	endfunction : pick
	// run up, drop enable, count ticks of reverse torque until power goes off
	task stop_run(input logic [31:0] c, input logic [15:0] dur, input int lo, input int hi);
		int nt, k;
		want <= 9'h000;
		axw(`A_CTRL, c, r);
		axw(`A_BRK_DUR, {16'h0, dur}, r);
		ticks(4);
		want <= 9'h010;
		ticks(3);
		chk(pwr, 1'b1);
		want <= 9'h000;
		nt = 0;
		for (k = 0; k < 40 && pwr; k++) begin
			ticks(1);
			if (trq) nt++;
		end
		chk(pwr, 1'b0);
		chk(nt >= lo && nt <= hi, 1'b1);
	endtask : stop_run
	// main sequence
	initial begin
		sys_rst = 1'b1;
		ce = 1'b1;
		want = 9'h000;
		{awvalid, wvalid, bready, arvalid, rready} = 5'h05;
		wstrb = 4'hF;
		awaddr = 8'h00;
		araddr = 8'h00;
		wdata = 32'h0;
		n_errors = 0;
		compares = 0;
		repeat (8) @(posedge clk_sys);
		sys_rst <= 1'b0;
		@(posedge clk_sys);
		i = $urandom(12105);
		axr(`A_CTRL, d, r);
		chk(d, `RST_CTRL);
		for (i = 2; i < 12; i++) begin
			cfg[i] = 16'($urandom);
			axw(8'(i * 4), {16'hFFFF, cfg[i]}, r);
			axr(8'(i * 4), d, r);
			chk(d, {16'h0, cfg[i]});
		end
		axr(8'h34, d, r);
		chk(r, `RESP_SLVERR);
		axw(`A_STATUS, 32'hFFFF, r);
		chk(r, `RESP_SLVERR);
		// partial strobe: only the low byte lane may change
		wstrb <= 4'h1;
		axw(8'h08, 32'hFFFF_FFCD, r);
		wstrb <= 4'hF;
		cfg[2][7:0] = 8'hCD;
		axr(8'h08, d, r);
		chk(d, {16'h0, cfg[2]});
		// gain and direction: exhaustive gain inputs first, then random
		for (i = 0; i < 48; i++) begin
			m = 9'($urandom);
			if (i < 16) m[3:0] = 4'(i);
			ctl = {28'h0, 1'b1, 3'($urandom)};
			axw(`A_CTRL, ctl, r);
			want <= m;
			ticks(3);
			chk(gs, exp_set(m));
			chk(sg, pick(m, 2, 5, 7));
			chk(si, pick(m, 3, 6, 8));
			chk(pg, pick(m, 4, 4, 9));
			chk(acs, m[0] ? cfg[11] : cfg[10]);
			chk(sgn, !m[2] && ctl[1]);
			if (m[2]) chk(dir, m[8] ^ ctl[0]);
			else if (!ctl[2]) chk(dir, m[5] ^ ctl[1]);
			else if (m[6] || m[7]) chk(dir, m[6] ^ ctl[1]);
			if (!m[2] && ctl[2]) chk(run, m[6] || m[7]);
			axr(`A_STATUS, d, r);
			chk(d[6:5], exp_set(m));
		end
		stop_run(32'h0, 16'h0005, 0, 0);
		stop_run(32'h8, 16'h0000, 1, 1);
		stop_run(32'h8, 16'h0005, 5, 5);
		// clock enable low freezes the sampled inputs and the gain set
		ce <= 1'b0;
		want <= 9'h002;
		ticks(3);
		chk(gs, servo_sel_pkg::GS_1);
		ce <= 1'b1;
		ticks(3);
		chk(gs, servo_sel_pkg::GS_3);
		// reset in mid-run returns outputs and register words to their reset values
		sys_rst <= 1'b1;
		repeat (2) @(posedge clk_sys);
		sys_rst <= 1'b0;
		@(posedge clk_sys);
		chk({gs, dir, run, sgn, pwr, trq}, {servo_sel_pkg::GS_1, 5'h10});
		axr(8'h08, d, r);
		chk(d, `RST_WORD);
		end_of_test();
	end
endmodule : servo_gain_direction_stop_select_bench
